// ===== energy_pulse_output_gen.sv
// Energy accumulation, output pulse generation and settings store
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Offset-removing high-pass filter
// ****************************************
module epog_hpf
  import epog_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic signed [SW-1:0] x,
  output logic signed [FW-1:0] y
);
  logic signed [FW-1:0] xPrev_r; // Previous input
  // y = x - x' + y' - y'/2^k, same for both channels so no phase skew
  always_ff @(posedge clk) begin
    if (rst) begin
      xPrev_r <= '0;
      y <= '0;
    end else if (en) begin
      xPrev_r <= FW'(x);
      y <= FW'(x) - xPrev_r + y - (y >>> HP_K);
    end
  end
endmodule : epog_hpf

// ****************************************
// Pulse shaper with width, gap and half-period limit
// ****************************************
module epog_shaper
  import epog_pkg::*;
#(
  parameter int WIDTH = 4,
  parameter int GAP = 0,
  parameter bit HALF = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic trig,
  output logic start,
  output logic pulse
);
  localparam logic [TW-1:0] W_T = TW'(WIDTH);
  localparam logic [TW-1:0] G_T = TW'(GAP);
  localparam logic [TW-1:0] P_MAX = TW'(2 * WIDTH);
  logic [TW-1:0] cnt_r; // Remaining high time
  logic [TW-1:0] gap_r; // Remaining forced idle
  logic [TW-1:0] per_r; // Clocks since last start
  logic pend_r; // Trigger waiting for idle
  logic [TW-1:0] half; // Half of last period
  logic [TW-1:0] wNxt; // Width for next pulse
  assign half = per_r >> 1;
  assign start = (trig | pend_r) & ~pulse & (gap_r == '0);
  // Short spacing falls back to 50% duty, never below one clock
  always_comb begin
    wNxt = W_T;
    if (HALF && half < W_T) begin
      wNxt = (half == '0) ? TW'(1) : half;
    end
  end
  // Period measurement, saturating so slow rates keep full width
  always_ff @(posedge clk) begin
    if (rst) begin
      per_r <= P_MAX;
    end else if (start) begin
      per_r <= '0;
    end else if (per_r != P_MAX) begin
      per_r <= per_r + TW'(1);
    end
  end
  // Pulse timing; one trigger may wait, a second one is merged
  always_ff @(posedge clk) begin
    if (rst) begin
      pulse <= 1'b0;
      cnt_r <= '0;
      gap_r <= '0;
      pend_r <= 1'b0;
    end else begin
      if (start) begin
        pulse <= 1'b1;
        cnt_r <= wNxt;
        pend_r <= 1'b0;
      end else begin
        if (trig) begin
          pend_r <= 1'b1;
        end
        if (pulse) begin
          cnt_r <= cnt_r - TW'(1);
          if (cnt_r == TW'(1)) begin
            pulse <= 1'b0;
            gap_r <= G_T;
          end
        end else if (gap_r != '0) begin
          gap_r <= gap_r - TW'(1);
        end
      end
    end
  end
endmodule : epog_shaper

// ****************************************
// Top level
// ****************************************
// Notes on behaviour
// - Gain code 11/10/00 gives 20/16/4
// - Unprogrammed gain code means gain 20
// - Sample every 2048 main clocks
// - Add energy each sample, compare threshold
// - Above threshold: pulse, subtract, keep remainder
// - All outputs from one energy stream
// - Trim rate is motor rate times 8..64
// - Unprogrammed trim rate is motor times 16
// - Trim pulse is high for 1 ms
// - Motor rate 100/200/400/800 per kWh
// - Unprogrammed motor rate is 400 per kWh
// - Motor pair drives stepper by difference
// - Motor pulse 200 ms, else 50% duty
// - Lamp rate 100 to 6400 per kWh
// - Lamp rate depends on its own code
// - Unprogrammed lamp rate is 3200 per kWh
// - Lamp pulse 80 ms, else 50% duty
// - Settings may be programmed twice
// - Identical high-pass filters on both channels
// - Direction low drops negative energy
// - Bidirectional indicator updates on trim/lamp pulse
// - Five idle clocks at least between motor phases
module energy_pulse_output_gen
  import epog_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_CYC,
  parameter int MOT_CYCLES = MOT_CYC,
  parameter int LED_CYCLES = LED_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic signed [SW-1:0] voltageSample,
  input wire logic signed [SW-1:0] currentSample,
  input wire logic direction_mode_in,
  input wire logic [7:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [31:0] rdData,
  output logic calPulseOut,
  output logic motor_drive_pos,
  output logic motorDriveNeg,
  output logic lampPulseOut,
  output logic direction_indicator_out
);
  // ****************************************
  // Settings store
  // ****************************************
  logic [CFG_W-1:0] stCfg_r; // Staged codes
  logic [31:0] stThr_r; // Staged threshold
  logic [CFG_W-1:0] nvCfg_r; // Committed codes
  logic [31:0] nvThr_r; // Committed threshold
  logic [1:0] progCnt_r; // Occasions used
  logic programmed; // Any commit made
  logic [1:0] gainCode, calCode, monCode;
  logic [2:0] ledCode;
  logic [31:0] thr; // Effective threshold
  assign programmed = progCnt_r != 2'h0;
  // Staging and commit; third commit is ignored
  always_ff @(posedge clk) begin
    if (rst) begin
      stCfg_r <= '0;
      stThr_r <= THR_DEF;
      nvCfg_r <= '0;
      nvThr_r <= THR_DEF;
      progCnt_r <= 2'h0;
    end else if (wrEn) begin
      if (addr == REG_STAGE_CFG) begin
        stCfg_r <= wrData[CFG_W-1:0];
      end
      if (addr == REG_STAGE_THR) begin
        stThr_r <= wrData;
      end
      if (addr == REG_COMMIT && progCnt_r < PROG_MAX) begin
        nvCfg_r <= stCfg_r;
        nvThr_r <= stThr_r;
        progCnt_r <= progCnt_r + 2'h1;
      end
    end
  end
  // Effective codes with defaults and reserved fallbacks
  always_comb begin
    gainCode = nvCfg_r[F_GAIN +: 2];
    if (!programmed || gainCode == GAIN_RSV) begin
      gainCode = GAIN_DEF;
    end
    ledCode = nvCfg_r[F_LED +: 3];
    if (!programmed || ledCode == LED_RSV) begin
      ledCode = LED_DEF;
    end
    calCode = programmed ? nvCfg_r[F_CAL +: 2] : CAL_DEF;
    monCode = programmed ? nvCfg_r[F_MON +: 2] : MON_DEF;
    thr = programmed ? nvThr_r : THR_DEF;
  end

  // ****************************************
  // Sample timing and direction input
  // ****************************************
  logic [10:0] divCnt_r; // Sample divider
  logic tick; // One clock per sample
  logic dirS1_r, dirMode_r; // Pin synchroniser
  assign tick = divCnt_r == 11'(SAMPLE_DIV - 1);
  // Free-running sample divider
  always_ff @(posedge clk) begin
    if (rst) begin
      divCnt_r <= '0;
    end else begin
      divCnt_r <= tick ? '0 : divCnt_r + 11'h1;
    end
  end
  // Direction mode pin crosses in; reset to bidirectional
  always_ff @(posedge clk) begin
    if (rst) begin
      dirS1_r <= 1'b1;
      dirMode_r <= 1'b1;
    end else begin
      dirS1_r <= direction_mode_in;
      dirMode_r <= dirS1_r;
    end
  end

  // ****************************************
  // Filters, gain and power
  // ****************************************
  logic signed [FW-1:0] fV, fI; // Filtered channels
  logic [5:0] gainF; // Gain factor
  logic signed [GW-1:0] gainedI;
  logic signed [PW-1:0] power;
  logic neg; // Negative energy this sample
  logic [PW-1:0] mag, addV; // Magnitude, amount added
  logic [AW-1:0] acc_r, accSum;
  logic basePulse_r; // One quantum crossed
  // Same filter for both channels
  epog_hpf uHpfV (.clk(clk), .rst(rst), .en(tick), .x(voltageSample), .y(fV));
  epog_hpf uHpfI (.clk(clk), .rst(rst), .en(tick), .x(currentSample), .y(fI));
  // Gain selection
  always_comb begin
    case (gainCode)
      2'h3: gainF = GAIN_X20;
      2'h2: gainF = GAIN_X16;
      2'h0: gainF = GAIN_X4;
      default: gainF = GAIN_X20;
    endcase
  end
  assign gainedI = fI * $signed({1'b0, gainF});
  assign power = fV * gainedI;
  assign neg = power < 0;
  assign mag = neg ? PW'(-power) : PW'(power);
  assign addV = (neg && !dirMode_r) ? '0 : mag;
  assign accSum = acc_r + AW'(addV);
  // Accumulate and subtract one quantum, keeping the rest
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_r <= '0;
      basePulse_r <= 1'b0;
    end else begin
      basePulse_r <= 1'b0;
      if (tick) begin
        if (accSum > AW'(thr)) begin
          acc_r <= accSum - AW'(thr);
          basePulse_r <= 1'b1;
        end else begin
          acc_r <= accSum;
        end
      end
    end
  end

  // ****************************************
  // Rate dividers: 0 trim, 1 motor, 2 lamp
  // ****************************************
  logic [3:0] shf [3]; // Log2 of division
  logic [DW-1:0] divC_r [3];
  logic fire_r [3]; // Divided pulse
  // Quantum is 51200 imp/kWh, so all rates are power-of-two divides
  always_comb begin
    shf[0] = 4'(BASE_LOG - CAL_LOG) - 4'(monCode) - 4'(calCode);
    shf[1] = 4'(BASE_LOG) - 4'(monCode);
    shf[2] = 4'(BASE_LOG) - 4'(ledCode);
  end
  // One quantum stream feeds every divider
  always_ff @(posedge clk) begin
    for (int k = 0; k < 3; k++) begin
      if (rst) begin
        divC_r[k] <= '0;
        fire_r[k] <= 1'b0;
      end else begin
        fire_r[k] <= 1'b0;
        if (basePulse_r) begin
          if (divC_r[k] >= (DW'(1) << shf[k]) - DW'(1)) begin
            divC_r[k] <= '0;
            fire_r[k] <= 1'b1;
          end else begin
            divC_r[k] <= divC_r[k] + DW'(1);
          end
        end
      end
    end
  end

  // ****************************************
  // Output shaping
  // ****************************************
  logic calStart, motStart, motPulse, ledStart;
  logic motSel_r; // Phase of current or last motor step, 1 = positive
  epog_shaper #(.WIDTH(CAL_CYCLES), .GAP(0), .HALF(1'b0)) uCal (
    .clk(clk), .rst(rst), .trig(fire_r[0]), .start(calStart), .pulse(calPulseOut));
  epog_shaper #(.WIDTH(MOT_CYCLES), .GAP(MOT_GAP), .HALF(1'b1)) uMot (
    .clk(clk), .rst(rst), .trig(fire_r[1]), .start(motStart), .pulse(motPulse));
  epog_shaper #(.WIDTH(LED_CYCLES), .GAP(0), .HALF(1'b1)) uLed (
    .clk(clk), .rst(rst), .trig(fire_r[2]), .start(ledStart), .pulse(lampPulseOut));
  // Motor steps alternate; both phases lag the shaper by one clock
  always_ff @(posedge clk) begin
    if (rst) begin
      motSel_r <= 1'b0;
      motor_drive_pos <= 1'b0;
      motorDriveNeg <= 1'b0;
    end else begin
      if (motStart) begin
        motSel_r <= ~motSel_r;
      end
      motor_drive_pos <= motPulse & motSel_r;
      motorDriveNeg <= motPulse & ~motSel_r;
    end
  end

  // ****************************************
  // Direction indicator
  // ****************************************
  logic lastNeg_r; // Sign of last nonzero sample
  // Bidirectional shows sign only at visible pulses to avoid flicker
  always_ff @(posedge clk) begin
    if (rst) begin
      lastNeg_r <= 1'b0;
      direction_indicator_out <= 1'b0;
    end else begin
      if (tick && mag != '0) begin
        lastNeg_r <= neg;
      end
      if (dirMode_r) begin
        if (calStart || ledStart) begin
          direction_indicator_out <= lastNeg_r;
        end
      end else if (tick && mag != '0) begin
        direction_indicator_out <= neg;
      end
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  // Read data valid the clock after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (rst) begin
      rdData <= '0;
    end else begin
      rdData <= '0;
      if (rdEn) begin
        case (addr)
          REG_STAGE_CFG: rdData <= 32'(stCfg_r);
          REG_STAGE_THR: rdData <= stThr_r;
          REG_COMMIT: rdData <= 32'(progCnt_r);
          REG_STATUS: rdData <= 32'({programmed, dirMode_r,
                                     direction_indicator_out, progCnt_r});
          REG_ACC: rdData <= acc_r[31:0];
          REG_EFF_CFG: rdData <= 32'({ledCode, monCode, calCode, gainCode});
          default: rdData <= '0;
        endcase
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [11:0] sinceTick_r; // Clocks since last sample
  always_ff @(posedge clk) begin
    if (rst) begin
      sinceTick_r <= '0;
    end else begin
      sinceTick_r <= tick ? '0 : sinceTick_r + 12'h1;
    end
  end
  sequence s_posEnd;
    $fell(motor_drive_pos);
  endsequence
  sequence s_negQuiet;
    !motorDriveNeg [*4];
  endsequence
  // Divider restarts from zero right after every sample
  property p_sample;
    @(posedge clk) disable iff (rst) $past(tick) |-> divCnt_r == '0 && !tick;
  endproperty
  a_sample: assert property (p_sample) else $error("tick off divider end");
  property p_spacing;
    @(posedge clk) disable iff (rst) (tick && sinceTick_r != '0)
      |-> sinceTick_r == 12'(SAMPLE_DIV - 1);
  endproperty
  a_spacing: assert property (p_spacing) else $error("sample spacing wrong");
  property p_sub;
    @(posedge clk) disable iff (rst) (tick && accSum > AW'(thr))
      |=> basePulse_r && acc_r == $past(accSum) - AW'($past(thr));
  endproperty
  a_sub: assert property (p_sub) else $error("remainder not kept");
  property p_uni;
    @(posedge clk) disable iff (rst) (tick && !dirMode_r && neg && accSum <= AW'(thr))
      |=> $stable(acc_r);
  endproperty
  a_uni: assert property (p_uni) else $error("negative energy counted");
  property p_gaindef;
    @(posedge clk) disable iff (rst) !programmed |-> gainF == GAIN_X20 && ledCode == LED_DEF;
  endproperty
  a_gaindef: assert property (p_gaindef) else $error("default gain or lamp lost");
  property p_calhold;
    @(posedge clk) disable iff (rst) $rose(calPulseOut) |=> calPulseOut [*2];
  endproperty
  a_calhold: assert property (p_calhold) else $error("trim pulse too short");
  property p_gap;
    @(posedge clk) disable iff (rst) s_posEnd |-> s_negQuiet;
  endproperty
  a_gap: assert property (p_gap) else $error("motor phase gap short");
  property p_excl;
    @(posedge clk) disable iff (rst) !(motor_drive_pos && motorDriveNeg);
  endproperty
  a_excl: assert property (p_excl) else $error("both motor phases high");
  property p_prog;
    @(posedge clk) disable iff (rst) (wrEn && addr == REG_COMMIT && progCnt_r == PROG_MAX)
      |=> $stable(nvCfg_r) && $stable(nvThr_r) && progCnt_r == PROG_MAX;
  endproperty
  a_prog: assert property (p_prog) else $error("third programming accepted");
  property p_dir;
    @(posedge clk) disable iff (rst) (dirMode_r && !calStart && !ledStart)
      |=> $stable(direction_indicator_out);
  endproperty
  a_dir: assert property (p_dir) else $error("indicator moved without pulse");
endmodule : energy_pulse_output_gen
`default_nettype wire

// ===== epog_pkg.sv
// Shared constants for the energy pulse output generator
package epog_pkg;
  // Clock and timing
  localparam int CLK_KHZ = 250000; // Main clock rate in kHz
  localparam int SAMPLE_DIV = 8 * 256; // Clocks per sample
  localparam int CAL_MS = 1; // Trim pulse width
  localparam int MOT_MS = 200; // Motor pulse width
  localparam int LED_MS = 80; // Lamp pulse width
  localparam int CAL_CYC = CLK_KHZ * CAL_MS;
  localparam int MOT_CYC = CLK_KHZ * MOT_MS;
  localparam int LED_CYC = CLK_KHZ * LED_MS;
  localparam int MOT_GAP = 4; // Gap count; idle clocks between motor phases are one more
  localparam int TW = 28; // Width of pulse timers
  // Datapath widths
  localparam int SW = 16; // Raw sample
  localparam int FW = 18; // Filtered sample
  localparam int GW = 24; // Current after gain
  localparam int PW = 42; // Instantaneous power
  localparam int AW = 46; // Energy accumulator
  localparam int HP_K = 8; // High-pass pole shift
  localparam int DW = 10; // Output divider counters
  localparam int BASE_LOG = 9; // Base rate is 512 x 100 imp/kWh
  localparam int CAL_LOG = 3; // Trim multiple is 8 << code
  // Register offsets
  localparam logic [7:0] REG_STAGE_CFG = 8'h00;
  localparam logic [7:0] REG_STAGE_THR = 8'h04;
  localparam logic [7:0] REG_COMMIT = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_ACC = 8'h10;
  localparam logic [7:0] REG_EFF_CFG = 8'h14;
  // Configuration field layout
  localparam int F_GAIN = 0;
  localparam int F_CAL = 2;
  localparam int F_MON = 4;
  localparam int F_LED = 6;
  localparam int CFG_W = 9;
  localparam logic [1:0] PROG_MAX = 2'h2; // Programming occasions
  // Defaults and reserved codes
  localparam logic [1:0] GAIN_DEF = 2'h3;
  localparam logic [1:0] GAIN_RSV = 2'h1;
  localparam logic [1:0] CAL_DEF = 2'h1;
  localparam logic [1:0] MON_DEF = 2'h2;
  localparam logic [2:0] LED_DEF = 3'h5;
  localparam logic [2:0] LED_RSV = 3'h7;
  localparam logic [5:0] GAIN_X20 = 6'h14;
  localparam logic [5:0] GAIN_X16 = 6'h10;
  localparam logic [5:0] GAIN_X4 = 6'h04;
  localparam logic [31:0] THR_DEF = 32'h0100_0000; // Plain default
endpackage : epog_pkg

// ===== epog_meter_model.sv
// Stepper counter and lamp model watching the pulse outputs
`timescale 1ns/1ps
`default_nettype none

// ****
// Far-side counter model
// ****
module epog_meter_model #(
  parameter int CAL_W = 20,
  parameter int LED_W = 80
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic calIn,
  input wire logic motPos,
  input wire logic motNeg,
  input wire logic lampIn,
  output int calCount,
  output int lampCount,
  output int stepCount,
  output int faults
);
  int calLen; // Clocks the trim pulse is high
  int lampLen; // Clocks the lamp pulse is high
  int gapLen; // Clocks with both motor phases low
  logic lastPos; // Phase of the previous step
  logic prevCal; // Trim level one clock ago
  logic prevLamp; // Lamp level one clock ago
  logic prevPos; // Positive phase one clock ago
  logic prevNeg; // Negative phase one clock ago

  // Counts rising edges, judges widths on falling edges
  always @(posedge clk) begin
    int bad;
    bad = 0;
    if (rst) begin
      calCount <= 0;
      lampCount <= 0;
      stepCount <= 0;
      faults <= 0;
      calLen <= 0;
      lampLen <= 0;
      gapLen <= 4; // Idle since reset counts as a full gap
      lastPos <= 1'b0;
      {prevCal, prevLamp, prevPos, prevNeg} <= 4'h0;
    end else begin
      {prevCal, prevLamp, prevPos, prevNeg} <= {calIn, lampIn, motPos, motNeg};
      calLen <= calIn ? calLen + 1 : 0;
      lampLen <= lampIn ? lampLen + 1 : 0;
      gapLen <= (motPos | motNeg) ? 0 : gapLen + 1;
      if (calIn && !prevCal) calCount <= calCount + 1;
      if (lampIn && !prevLamp) lampCount <= lampCount + 1;
      if (!calIn && prevCal && calLen != CAL_W) bad++;
      // Spacing in the bench is long, so full width is due
      if (!lampIn && prevLamp && lampLen != LED_W) bad++;
      if (motPos && motNeg) bad++;
      if ((motPos && !prevPos) || (motNeg && !prevNeg)) begin
        stepCount <= stepCount + 1;
        if (gapLen < 4) bad++;
        if (motPos == lastPos && stepCount > 0) bad++;
        if (motNeg && stepCount == 0) bad++;
        lastPos <= motPos;
      end
      faults <= faults + bad;
    end
  end
endmodule : epog_meter_model

`default_nettype wire

// ===== test_energy_pulse_output_gen.sv
// Self-checking bench for the energy pulse output generator
`timescale 1ns/1ps
`default_nettype none

module test_energy_pulse_output_gen import epog_pkg::*;;
  // ****
  // Signals
  // ****
  logic clk;
  logic rst;
  logic signed [SW-1:0] voltageSample;
  logic signed [SW-1:0] currentSample;
  logic direction_mode_in;
  logic [7:0] addr;
  logic [31:0] wrData;
  logic wrEn;
  logic rdEn;
  logic [31:0] rdData;
  logic calPulseOut;
  logic motor_drive_pos;
  logic motorDriveNeg;
  logic lampPulseOut;
  logic direction_indicator_out;
  logic [31:0] expQ[$]; // Expected read data, oldest first
  logic rdPend = 1'b0; // Read taken last edge
  logic run; // Sample stimulus on
  logic negPow; // Current opposite to voltage
  logic sgn = 1'b0; // Square wave polarity
  logic [10:0] phase = 11'h000; // Wraps once per sample period
  logic signed [SW-1:0] amp; // Random drive amplitude
  int calCount, lampCount, stepCount, faults;
  int errors = 0;
  int checks_done = 0;

  // Shortened widths keep the run small
  energy_pulse_output_gen #(.CAL_CYCLES(20), .MOT_CYCLES(200), .LED_CYCLES(80))
    energy_pulse_output_gen_inst (.clk(clk), .rst(rst), .voltageSample(voltageSample),
    .currentSample(currentSample), .direction_mode_in(direction_mode_in), .addr(addr),
    .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .calPulseOut(calPulseOut),
    .motor_drive_pos(motor_drive_pos), .motorDriveNeg(motorDriveNeg),
    .lampPulseOut(lampPulseOut), .direction_indicator_out(direction_indicator_out));

  epog_meter_model #(.CAL_W(20), .LED_W(80)) epog_meter_model_inst (.clk(clk), .rst(rst),
    .calIn(calPulseOut), .motPos(motor_drive_pos), .motNeg(motorDriveNeg),
    .lampIn(lampPulseOut), .calCount(calCount), .lampCount(lampCount),
    .stepCount(stepCount), .faults(faults));

  // ****
  // Tasks
  // ****
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One bus cycle; each call assigns the strobes once, so calls may abut
  task automatic bus(input logic w, input logic r, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] e);
    addr <= a;
    wrData <= d;
    wrEn <= w;
    rdEn <= r;
    if (r) expQ.push_back(e);
    @(posedge clk);
  endtask : bus

  task automatic do_reset;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask : do_reset

  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim

  // ****
  // Clock, stimulus and monitor
  // ****
  always #2 clk = ~clk;

  // Square wave at half the sample rate, so the offset filter passes it
  always @(posedge clk) begin
    phase <= phase + 11'h001;
    if (phase == 11'h7ff) sgn <= ~sgn;
    voltageSample <= run ? (sgn ? amp : -amp) : 16'sh0000;
    currentSample <= run ? ((sgn ^ negPow) ? amp : -amp) : 16'sh0000;
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    rdPend <= rdEn;
    if (rdPend) begin
      if (expQ.size() == 0) check("readQueue", 32'h1, 32'h0);
      else check("rdData", rdData, expQ.pop_front());
    end
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    end_sim();
  end

  // ****
  // Main sequence
  // ****
  initial begin
    logic [31:0] c, e, rnd;
    int c0, seedVal;
    clk = 1'b0;
    rst = 1'b1;
    {addr, wrData, wrEn, rdEn, run, negPow} = 0;
    direction_mode_in = 1'b1;
    seedVal = $urandom(78495);
    // Narrow amplitude range keeps power just below the threshold
    amp = {4'h1, 4'h0, 8'($urandom)};
    rnd = $urandom;
    // Every code of every field, one fresh device each
    for (int i = 0; i < 8; i++) begin
      do_reset();
      c = {23'h0, 3'(i), 2'(i + 1), 2'(i + 2), 2'(i)};
      e = {23'h0, (i == 7) ? 3'h5 : 3'(i), c[5:2], (c[1:0] == 2'h1) ? 2'h3 : c[1:0]};
      if (i == 0) begin
        bus(0, 1, REG_EFF_CFG, 0, 32'h0000_0167);
        bus(0, 1, REG_STATUS, 0, 32'h0000_0008);
        bus(0, 1, REG_STAGE_THR, 0, THR_DEF);
        bus(0, 1, 8'h20, 0, 32'h0);
        bus(1, 0, REG_STAGE_THR, rnd, 0);
        bus(0, 1, REG_STAGE_THR, 0, rnd);
      end
      bus(1, 0, REG_STAGE_CFG, c, 0);
      bus(0, 1, REG_STAGE_CFG, 0, c);
      bus(1, 0, REG_COMMIT, 0, 0);
      bus(0, 1, REG_EFF_CFG, 0, e);
      bus(0, 1, REG_STATUS, 0, 32'h0000_0019);
      if (i == 7) begin
        // Third commit must be ignored
        bus(1, 0, REG_COMMIT, 0, 0);
        bus(1, 0, REG_COMMIT, 0, 0);
        bus(0, 1, REG_STATUS, 0, 32'h0000_001a);
        bus(0, 1, REG_COMMIT, 0, 32'h0000_0002);
      end
      bus(0, 0, 0, 0, 0);
      @(posedge clk);
      $display("config case %0d done", i);
    end
    // Fastest trim, lamp code 110; threshold just above one sample's energy,
    // so the remainder stays below it and a quantum comes on most samples
    do_reset();
    bus(1, 0, REG_STAGE_CFG, 32'h0000_01bf, 0);
    bus(1, 0, REG_STAGE_THR, 32'h1800_0000, 0);
    bus(1, 0, REG_COMMIT, 0, 0);
    bus(0, 0, 0, 0, 0);
    run <= 1'b1;
    repeat (24 * 2048) @(posedge clk);
    check("calCount", 32'(calCount >= 16 && calCount <= 24), 32'h1);
    check("lampRatio", 32'(lampCount + 1 >= calCount / 8 && lampCount <= calCount / 8 + 1),
          32'h1);
    check("dirOut", 32'(direction_indicator_out), 32'h0);
    $display("forward energy done");
    // Reverse energy, unidirectional: nothing counted
    direction_mode_in <= 1'b0;
    negPow <= 1'b1;
    c0 = calCount;
    repeat (6 * 2048) @(posedge clk);
    check("uniDelta", 32'(calCount - c0 <= 2), 32'h1);
    $display("unidirectional done");
    // Reverse energy, bidirectional: counted, indicator set
    direction_mode_in <= 1'b1;
    c0 = calCount;
    repeat (6 * 2048) @(posedge clk);
    check("biDelta", 32'(calCount - c0 >= 3), 32'h1);
    check("dirOut", 32'(direction_indicator_out), 32'h1);
    bus(0, 1, REG_STATUS, 0, 32'h0000_001d);
    bus(0, 0, 0, 0, 0);
    repeat (2) @(posedge clk);
    check("modelFaults", 32'(faults), 32'h0);
    $display("bidirectional done");
    end_sim();
  end
endmodule : test_energy_pulse_output_gen

`default_nettype wire
